// File: core/tgc_gate.sv
// timer gate control: source select, polarity, toggle, single pulse, gate event irq, AXI4-Lite slave
// Operation
// - two-bit select picks pin, eight-bit timer overflow, comparator 1 or comparator 2.
// - polarity bit inverts or passes the selected source.
// - eight-bit timer wrap FFh to 00h gives one rising pulse as source.
// - each comparator source used synchronized or raw, per its sync bit.
// - toggle mode flips a flip-flop on each rising gate edge.
// - toggle enable low forces and holds the toggle flip-flop at zero.
// - single pulse enable then arm; counting starts on next rising gate edge.
// - arm clears itself on the trailing edge of the captured pulse.
// - after capture, gate events ignored until arm is set again.
// - toggle and single pulse together capture one full source cycle.
// - read-only level status shows the processed gate level.
// - level status stays live while gate enable is clear.
// - falling edge of level status sets the gate event flag.
// - interrupt requested while gate event flag and its enable are set.
// - gate event flag keeps working while gate enable is clear.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "tgc_regs.svh"

module tgc_gate (
  // clock and reset
  input  wire logic                   CLK_I,
  input  wire logic                   NRST_I,
  // gate sources
  input  wire logic                   GATE_INPUT_PIN_I,
  input  wire logic [7:0]             EIGHT_BIT_TIMER_COUNT_I,
  input  wire logic [1:0]             CMP_OUT_I,
  // timer side
  output logic                        COUNT_EN_O,
  output logic                        GATE_LEVEL_O,
  output logic                        IRQ_O,
  // AXI4-Lite write address
  input  wire logic [`TGC_ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic                   S_AXI_AWVALID_I,
  output logic                        S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input  wire logic [31:0]            S_AXI_WDATA_I,
  input  wire logic [3:0]             S_AXI_WSTRB_I,
  input  wire logic                   S_AXI_WVALID_I,
  output logic                        S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]                  S_AXI_BRESP_O,
  output logic                        S_AXI_BVALID_O,
  input  wire logic                   S_AXI_BREADY_I,
  // AXI4-Lite read address
  input  wire logic [`TGC_ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic                   S_AXI_ARVALID_I,
  output logic                        S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0]                 S_AXI_RDATA_O,
  output logic [1:0]                  S_AXI_RRESP_O,
  output logic                        S_AXI_RVALID_O,
  input  wire logic                   S_AXI_RREADY_I
);
  import tgc_pkg::*;

  tgc_state_t r;
  tgc_state_t n;
  logic       ovf;
  logic       cmp1;
  logic       cmp2;
  logic       src;
  logic       g;
  logic       g_rise;
  logic       tg;
  logic       tg_rise;
  logic       tg_fall;
  logic       proc;
  logic       ev_set;
  logic       wr_fire;
  logic [9:0] wval;

  always_comb
  begin
    n = r;
    // inputs are synchronous; the comparators still get a two-stage path when asked
    n.cmp_s1 = CMP_OUT_I;
    n.cmp_s2 = r.cmp_s1;
    n.t0_prev = EIGHT_BIT_TIMER_COUNT_I;
    ovf = (r.t0_prev == `TGC_T0_MAX) && (EIGHT_BIT_TIMER_COUNT_I == `TGC_T0_WRAP);
    cmp1 = r.ctrl.cmp1_sync ? r.cmp_s2[0] : CMP_OUT_I[0];
    cmp2 = r.ctrl.cmp2_sync ? r.cmp_s2[1] : CMP_OUT_I[1];
    case (r.ctrl.gate_source_select)
      `TGC_SRC_PIN:   src = GATE_INPUT_PIN_I;
      `TGC_SRC_T0OVF: src = ovf;
      `TGC_SRC_CMP1:  src = cmp1;
      `TGC_SRC_CMP2:  src = cmp2;
      default:        src = 1'b0;
    endcase
    g = src ^ r.ctrl.gate_polarity;
    n.g_prev = g;
    g_rise = g & ~r.g_prev;
    if (!r.ctrl.gate_toggle_enable)
    begin
      n.tog = 1'b0;
    end
    else if (g_rise)
    begin
      n.tog = ~r.tog;
    end
    // toggle output feeds the single-pulse stage, so both together catch a full cycle
    tg = r.ctrl.gate_toggle_enable ? n.tog : g;
    n.tg_prev = tg;
    tg_rise = tg & ~r.tg_prev;
    tg_fall = ~tg & r.tg_prev;
    case (r.sp)
      SP_IDLE:
      begin
        if (r.ctrl.gate_single_pulse_enable && r.ctrl.gate_pulse_arm && tg_rise)
        begin
          n.sp = SP_RUN;
        end
      end
      SP_RUN:
      begin
        if (!r.ctrl.gate_single_pulse_enable || !r.ctrl.gate_pulse_arm)
        begin
          n.sp = SP_IDLE;
        end
        else if (tg_fall)
        begin
          n.sp = SP_IDLE;
          n.ctrl.gate_pulse_arm = 1'b0;
        end
      end
      default: n.sp = SP_IDLE;
    endcase
    // idle without arm blocks every further edge
    proc = r.ctrl.gate_single_pulse_enable ? (n.sp == SP_RUN) : tg;
    // no dependence on gate enable here
    n.gval = proc;
    n.ctrl.gate_level_status = proc;
    ev_set = r.gval & ~proc;

    // write side
    if (r.bvalid && S_AXI_BREADY_I)
    begin
      n.bvalid = 1'b0;
    end
    if (S_AXI_AWVALID_I && r.awready)
    begin
      n.aw_full = 1'b1;
      n.wr.awaddr = S_AXI_AWADDR_I[3:2];
    end
    if (S_AXI_WVALID_I && r.wready)
    begin
      n.w_full = 1'b1;
      n.wr.wdata = S_AXI_WDATA_I[9:0];
      n.wr.wstrb = S_AXI_WSTRB_I[1:0];
    end
    wr_fire = n.aw_full && n.w_full && !n.bvalid;
    wval = n.ctrl;
    if (n.wr.wstrb[0])
    begin
      wval[7:0] = n.wr.wdata[7:0];
    end
    if (n.wr.wstrb[1])
    begin
      wval[9:8] = n.wr.wdata[9:8];
    end
    if (wr_fire)
    begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `TGC_RESP_OKAY;
      case (n.wr.awaddr)
        `TGC_OFS_CTRL:
        begin
          // level status is read-only; software arm write beats the hardware clear
          n.ctrl = tgc_ctrl_t'({wval[9:3], n.ctrl.gate_level_status, wval[1:0]});
        end
        `TGC_OFS_STAT:
        begin
          if (n.wr.wstrb[0] && n.wr.wdata[0])
          begin
            n.gate_event_flag = 1'b0;
          end
        end
        `TGC_OFS_MASK:
        begin
          if (n.wr.wstrb[0])
          begin
            n.gate_event_irq_enable = n.wr.wdata[0];
          end
        end
        default: n.bresp = `TGC_RESP_SLVERR;
      endcase
    end
    // set wins over a same-cycle clear
    if (ev_set)
    begin
      n.gate_event_flag = 1'b1;
    end
    n.awready = !n.aw_full && !n.bvalid;
    n.wready = !n.w_full && !n.bvalid;

    // read side
    if (r.rvalid && S_AXI_RREADY_I)
    begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = `TGC_RESP_OKAY;
      case (S_AXI_ARADDR_I[3:2])
        `TGC_OFS_CTRL: n.rdata = r.ctrl;
        `TGC_OFS_STAT: n.rdata = {9'h000, r.gate_event_flag};
        `TGC_OFS_MASK: n.rdata = {9'h000, r.gate_event_irq_enable};
        default:
        begin
          n.rdata = 10'h000;
          n.rresp = `TGC_RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;

    n.irq = n.gate_event_flag && n.gate_event_irq_enable;
    // without gate enable the gate never holds the count back
    n.cnt_en = !n.ctrl.gate_enable || proc;
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign COUNT_EN_O      = r.cnt_en;
  assign GATE_LEVEL_O    = r.gval;
  assign IRQ_O           = r.irq;
  assign S_AXI_AWREADY_O = r.awready;
  assign S_AXI_WREADY_O  = r.wready;
  assign S_AXI_BRESP_O   = r.bresp;
  assign S_AXI_BVALID_O  = r.bvalid;
  assign S_AXI_ARREADY_O = r.arready;
  assign S_AXI_RDATA_O   = {22'h000000, r.rdata};
  assign S_AXI_RRESP_O   = r.rresp;
  assign S_AXI_RVALID_O  = r.rvalid;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_ovf_one_pulse: assert property (
    (r.ctrl.gate_source_select == `TGC_SRC_T0OVF && ovf) |=> !ovf)
    else $error("overflow gate pulse longer than one cycle");
  a_source_polarity: assert property (
    (r.ctrl.gate_source_select == `TGC_SRC_PIN && !r.ctrl.gate_toggle_enable
     && !r.ctrl.gate_single_pulse_enable) |=> (r.gval == ($past(GATE_INPUT_PIN_I) ^ $past(r.ctrl.gate_polarity))))
    else $error("gate level does not follow pin and polarity");
  a_toggle_flip: assert property (
    (r.ctrl.gate_toggle_enable && g_rise) |=> (r.tog != $past(r.tog)))
    else $error("toggle flip-flop missed a rising edge");
  a_toggle_held: assert property (
    !r.ctrl.gate_toggle_enable |=> !r.tog)
    else $error("toggle flip-flop not held clear");
  a_pulse_start: assert property (
    (r.sp == SP_IDLE && r.ctrl.gate_single_pulse_enable && r.ctrl.gate_pulse_arm && tg_rise) |=> (r.gval && r.sp == SP_RUN))
    else $error("armed single pulse did not start on rising edge");
  a_arm_clear: assert property (
    (r.sp == SP_RUN && r.ctrl.gate_single_pulse_enable && r.ctrl.gate_pulse_arm && tg_fall && !wr_fire)
    |=> (!r.ctrl.gate_pulse_arm && !r.gval))
    else $error("arm not cleared at pulse end");
  a_pulse_ignore: assert property (
    (r.ctrl.gate_single_pulse_enable && !r.ctrl.gate_pulse_arm) |=> !r.gval)
    else $error("gate active while single pulse is disarmed");
  a_flag_on_fall: assert property (
    $fell(r.gval) |-> r.gate_event_flag)
    else $error("gate event flag not set on falling level");
  a_irq_level: assert property (
    (r.gate_event_flag && r.gate_event_irq_enable) |-> ##[0:1] IRQ_O)
    else $error("interrupt missing while flag and enable set");
  a_count_gate: assert property (
    (r.ctrl.gate_enable && !r.gval) |-> !COUNT_EN_O)
    else $error("counting while gate inactive");
  a_bvalid_hold: assert property (
    (S_AXI_BVALID_O && !S_AXI_BREADY_I) |=> S_AXI_BVALID_O)
    else $error("write response dropped before taken");

  c_pulse_done: cover property (r.sp == SP_RUN ##1 r.sp == SP_IDLE && !r.ctrl.gate_pulse_arm);
  c_flag_set: cover property ($rose(r.gate_event_flag));
  c_toggle_pulse: cover property (r.ctrl.gate_toggle_enable && r.ctrl.gate_single_pulse_enable && $fell(r.gval));
  c_irq: cover property ($rose(IRQ_O));

endmodule

// File: core/tgc_pkg.sv
// types of the timer gate control block
package tgc_pkg;

  // gate control register, bit 9 down to bit 0
  typedef struct packed {
    logic       cmp2_sync;
    logic       cmp1_sync;
    logic       gate_enable;
    logic       gate_polarity;
    logic       gate_toggle_enable;
    logic       gate_single_pulse_enable;
    logic       gate_pulse_arm;
    logic       gate_level_status;
    logic [1:0] gate_source_select;
  } tgc_ctrl_t;

  typedef enum logic [0:0] {
    SP_IDLE,
    SP_RUN
  } tgc_sp_t;

  typedef struct packed {
    logic [1:0] awaddr;
    logic [1:0] wstrb;
    logic [9:0] wdata;
  } tgc_wr_t;

  typedef struct packed {
    tgc_ctrl_t  ctrl;
    logic       gate_event_flag;
    logic       gate_event_irq_enable;
    tgc_sp_t    sp;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [7:0] t0_prev;
    logic       g_prev;
    logic       tog;
    logic       tg_prev;
    logic       gval;
    logic       cnt_en;
    logic       irq;
    logic       aw_full;
    logic       w_full;
    tgc_wr_t    wr;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [9:0] rdata;
  } tgc_state_t;

endpackage

// File: core/tgc_regs.svh
// register offsets, reset values and constants of the timer gate control block
`ifndef TGC_REGS_SVH
`define TGC_REGS_SVH

`define TGC_ADDR_W      4
`define TGC_OFS_CTRL    2'h0
`define TGC_OFS_STAT    2'h1
`define TGC_OFS_MASK    2'h2
`define TGC_CTRL_W      10
`define TGC_CTRL_RST    10'h000
`define TGC_STAT_RST    1'h0
`define TGC_MASK_RST    1'h0
`define TGC_SRC_PIN     2'h0
`define TGC_SRC_T0OVF   2'h1
`define TGC_SRC_CMP1    2'h2
`define TGC_SRC_CMP2    2'h3
`define TGC_T0_MAX      8'hFF
`define TGC_T0_WRAP     8'h00
`define TGC_RESP_OKAY   2'h0
`define TGC_RESP_SLVERR 2'h2

`endif

// File: verification/tgc_src_model.sv
// far-side gate sources: pin, eight-bit timer count, comparator outputs
module tgc_src_model (
  // control from the bench
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [2:0] lvl_i,
  // sources seen by the gate logic
  output logic            pin_o,
  output logic [7:0]      cnt_o,
  output logic [1:0]      cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // starts near the top so a wrap comes quickly
  initial cnt_o = 8'hFA;
  always @(posedge clk_i)
    if (run_i)
      cnt_o <= cnt_o + 8'h01;
  assign pin_o = lvl_i[0];
  assign cmp_o = lvl_i[2:1];
endmodule

// File: verification/timer_gate_control_tb_top.sv
// self-checking bench of the timer gate control block
module timer_gate_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_I = 1'b0;
  logic        NRST_I = 1'b0;
  logic        run = 1'b0;
  logic [2:0]  lvl = 3'h0;
  logic        pin, cen, glv, irq, x;
  logic        cen_w, glv_w, irq_w;
  logic [7:0]  cnt;
  logic [1:0]  cmp, bresp, rresp, resp;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd_v;
  logic [31:0] seed = 32'h09B4;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_errors = 0;
  int          n_checks = 0;
  int          e, i;

  tgc_src_model SRC (.clk_i(CLK_I), .run_i(run), .lvl_i(lvl), .pin_o(pin), .cnt_o(cnt), .cmp_o(cmp));
  tgc_gate DUT (.CLK_I(CLK_I), .NRST_I(NRST_I), .GATE_INPUT_PIN_I(pin), .EIGHT_BIT_TIMER_COUNT_I(cnt),
    .CMP_OUT_I(cmp), .COUNT_EN_O(cen_w), .GATE_LEVEL_O(glv_w), .IRQ_O(irq_w),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));

  initial
  begin
    forever #5 CLK_I = ~CLK_I;
  end

  // outputs taken mid-cycle, so a check at a rising edge never races the flops
  always @(negedge CLK_I)
  begin
    cen = cen_w;
    glv = glv_w;
    irq = irq_w;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  // both channels offered together, each released at its own handshake
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int   k;
    logic done, ta, tw, tb;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // handshakes judged on values that stand just before the next rising edge
    for (k = 0; k < 50 && !done; k++)
    begin
      @(negedge CLK_I);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb)
        resp = bresp;
      @(posedge CLK_I);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
      begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      n_errors++;
      wrap_up();
    end
    tick(1);
  endtask

  task automatic rd(input logic [3:0] a);
    int   k;
    logic done, ta, tr;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50 && !done; k++)
    begin
      @(negedge CLK_I);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr)
      begin
        rd_v = rdata;
        resp = rresp;
      end
      @(posedge CLK_I);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
      begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      n_errors++;
      wrap_up();
    end
    tick(1);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d of %0d comparisons", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    tick(8);
    NRST_I <= 1'b1;
    tick(2);
    for (e = 0; e < 3; e++)
    begin
      rd(4'(4 * e));
      chk("reset value", rd_v, 32'h0);
    end
    rd(4'hC);
    chk("unmapped read", {rd_v[29:0], resp}, 32'h2);
    wr(4'hC, 32'h1);
    chk("unmapped write", resp, 32'h2);
    // every source and polarity, random levels and sync choices
    for (e = 0; e < 24; e++)
    begin
      seed = lfsr(seed);
      wr(4'h0, {22'h0, seed[9:7], e[0], 4'h0, e[2:1]});
      lvl <= seed[2:0];
      tick(5);
      x = (({seed[2:1], 1'b0, seed[0]} >> e[2:1]) & 4'h1) ^ e[0];
      chk("gate level", glv, x);
      chk("count enable", cen, !seed[7] | x);
      rd(4'h0);
      chk("level status", rd_v[2], x);
    end
    wr(4'h0, 32'h0);
    lvl <= 3'h1;
    tick(4);
    wr(4'h4, 32'h1);
    rd(4'h4);
    chk("flag cleared", rd_v, 32'h0);
    wr(4'h8, 32'h1);
    chk("irq idle", irq, 1'b0);
    lvl <= 3'h0;
    tick(4);
    chk("irq raised", irq, 1'b1);
    rd(4'h4);
    chk("flag set", rd_v, 32'h1);
    wr(4'h8, 32'h0);
    tick(2);
    chk("irq masked", irq, 1'b0);
    // toggle written alone, polarity untouched
    wr(4'h0, 32'h20);
    x = 1'b0;
    for (i = 0; i < 3; i++)
    begin
      lvl <= 3'h1;
      tick(3);
      lvl <= 3'h0;
      tick(3);
      x = ~x;
      chk("toggle level", glv, x);
    end
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h20);
    tick(3);
    chk("toggle cleared", glv, 1'b0);
    wr(4'h0, 32'h90);
    wr(4'h0, 32'h98);
    tick(3);
    chk("armed idle", cen, 1'b0);
    lvl <= 3'h1;
    tick(3);
    chk("pulse counted", cen, 1'b1);
    lvl <= 3'h0;
    tick(3);
    chk("pulse ended", cen, 1'b0);
    rd(4'h0);
    chk("arm done", rd_v[4:3], 2'h2);
    lvl <= 3'h1;
    tick(3);
    chk("later pulse", cen, 1'b0);
    lvl <= 3'h0;
    wr(4'h0, 32'h0);
    wr(4'h0, 32'hB0);
    wr(4'h0, 32'hB8);
    for (i = 0; i < 3; i++)
    begin
      lvl <= {2'h0, ~i[0]};
      tick(3);
      chk("full cycle", cen, i < 2);
    end
    lvl <= 3'h0;
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h21);
    tick(3);
    run <= 1'b1;
    tick(20);
    run <= 1'b0;
    tick(3);
    chk("one wrap pulse", glv, 1'b1);
    wrap_up();
  end
endmodule
